// file: logic/atc_defines.svh
`ifndef ATC_DEFINES_SVH
`define ATC_DEFINES_SVH
// ==============================
// widths and depths
`define ATC_SIZE_W 16
`define ATC_CNT_W 16
`define ATC_FIFO_DEPTH 8
// ==============================
// capture mode and transfer method encodings
`define ATC_MODE_ONE_SHOT 2'h0
`define ATC_MODE_COUNTED 2'h1
`define ATC_MODE_CONTINUOUS 2'h2
`define ATC_XFER_BASIC 1'b0
// ==============================
// queue memory and link figures (block sizes are in 1/1024 megabyte units)
`define ATC_QUEUE_TOTAL_MB 8'h60
`define ATC_LINK_KB_PER_S 17'h1cc00
`define ATC_MEAN_SHIFT 4
// ==============================
// rate divider last step index (steps 0 to 16)
`define ATC_DIV_LAST 5'h10
`endif

// file: logic/atc_pkg.sv
`include "atc_defines.svh"
package atc_pkg;
   // ==============================
   // capture sequencer states, one-hot
   typedef enum logic [2:0] {
      ATC_IDLE = 3'b001,
      ATC_WAIT = 3'b010,
      ATC_CAPT = 3'b100
   } atc_state_t;

   // ==============================
   // complete control state of the sequencer
   typedef struct packed {
      atc_state_t state;
      logic armed;
      logic xferDirty;
      logic regOk;
      logic regBatch;
      logic featBatch;
      logic stopPend;
      logic autoArm;
      logic discard;
      logic [1:0] actMode;
      logic [`ATC_CNT_W-1:0] actCount;
      logic [`ATC_CNT_W-1:0] actPerTrig;
      logic [`ATC_CNT_W-1:0] frameCnt;
      logic [`ATC_CNT_W-1:0] burstCnt;
      logic seenAny;
      logic [`ATC_SIZE_W-1:0] largest;
      logic [`ATC_SIZE_W-1:0] smallest;
      logic [`ATC_SIZE_W+3:0] meanSum;
      logic [7:0] qMem;
      logic divBusy;
      logic [4:0] divStep;
      logic [16:0] divRem;
      logic [16:0] divQuo;
      logic [`ATC_SIZE_W-1:0] divDen;
      logic [`ATC_SIZE_W-1:0] rate;
   } atc_ctrl_t;
endpackage : atc_pkg

// file: logic/atc_fifo.sv
`timescale 1ns/1ps
module atc_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 8
) (
   input wire logic clock,
   input wire logic resetn,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData,
   output logic [$clog2(DEPTH+1)-1:0] count
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] rd;
      logic [AW-1:0] wr;
      logic [CW-1:0] cnt;
   } atc_fifo_st_t;

   atc_fifo_st_t st_reg;
   atc_fifo_st_t st_next;
   logic push;
   logic pop;

   // ==============================
   // handshakes; full and empty come straight from the count
   assign inReady = st_reg.cnt != CW'(DEPTH);
   assign outValid = st_reg.cnt != '0;
   assign outData = st_reg.mem[st_reg.rd];
   assign count = st_reg.cnt;
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   // next state: write, read and count update
   always_comb begin
      st_next = st_reg;
      if (push) begin
         st_next.mem[st_reg.wr] = inData;
         st_next.wr = st_reg.wr + 1'b1; // depth is a power of two, so pointers wrap
      end
      if (pop) begin
         st_next.rd = st_reg.rd + 1'b1;
      end
      if (push && !pop) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop && !push) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
endmodule : atc_fifo

// file: logic/atc_acq_ctrl.sv
`timescale 1ns/1ps
`include "atc_defines.svh"
// ==============================
// Functional notes
// - first start without prior arm performs the arm automatically
// - auto arm repeats only if a transfer setting changed since last arm, or if that arm failed its consistency check
// - arm checks settings for consistency and readies fast capture start
// - start begins capture, frame count governed by the active capture mode
// - stop ends after current frame, or after burst when frames per trigger exceeds 1
// - abort ends capture at once, discards the frame, cancels trigger wait
// - abort while idle is ignored
// - basic transfer method, frames sent without host pacing
// - number of blocks waiting in the transfer queue is readable
// - queue memory in megabytes shrinks as resend reservation grows
// - largest transmitted block size is tracked
// - smallest size tracked; largest and smallest cleared when capture stops
// - leaky running mean of transmitted block sizes, each new size weighted one sixteenth
// - sustainable frame rate from block size, link limit and sensor limit
// - register batch begin defers consistency checks on writes
// - register batch commit validates before settings become active
// - feature batch defers checks and validates at commit
// - explicit validate command checks the current settings
// - readable flag tells whether the setting set is consistent
// - one-shot mode captures one frame then stops
// - counted burst mode captures the programmed count then stops
// - continuous mode captures until stopped
// - selectable status shows capture active or waiting for trigger
module atc_acq_ctrl (
   input wire logic clock,
   input wire logic resetn,
   input wire logic armCommand,
   input wire logic captureStartCommand,
   input wire logic captureStopCommand,
   input wire logic captureAbortCommand,
   input wire logic [1:0] captureModeSelect,
   input wire logic [`ATC_CNT_W-1:0] burstFrameCount,
   input wire logic [`ATC_CNT_W-1:0] framesPerTrigger,
   input wire logic transferMethodSelect,
   input wire logic transferSettingChanged,
   input wire logic triggerModeOn,
   input wire logic triggerIn,
   input wire logic regBatchBegin,
   input wire logic regBatchCommit,
   input wire logic featureBatchBegin,
   input wire logic featureBatchCommit,
   input wire logic regSetValidate,
   output logic captureEnable,
   input wire logic frameDone,
   input wire logic [`ATC_SIZE_W-1:0] frameSize,
   output logic txValid,
   output logic [`ATC_SIZE_W-1:0] txSize,
   input wire logic txReady,
   input wire logic [7:0] resendBufferReservation,
   input wire logic compressionOn,
   input wire logic [`ATC_SIZE_W-1:0] configuredBlockSize,
   input wire logic [`ATC_SIZE_W-1:0] sensorRateLimit,
   input wire logic statusSelect,
   output logic acquisitionStatus,
   output logic captureInProgress,
   output logic awaitingTrigger,
   output logic [3:0] queuedBlockCount,
   output logic [7:0] queueMemoryMegabytes,
   output logic [`ATC_SIZE_W-1:0] largestSentBlock,
   output logic [`ATC_SIZE_W-1:0] smallestSentBlock,
   output logic [`ATC_SIZE_W-1:0] meanSentBlock,
   output logic [`ATC_SIZE_W-1:0] sustainableFrameRate,
   output logic regSetOkFlag,
   output logic autoArmPulse,
   output logic frameDiscard
);
   atc_pkg::atc_ctrl_t r_reg;
   atc_pkg::atc_ctrl_t r_next;
   logic setOk;
   logic idle;
   logic needArm;
   logic doArm;
   logic fifoInReady;
   logic pushValid;
   logic accepted;
   logic pop;

   // ==============================
   // consistency of the settings as presented now
   assign setOk = (captureModeSelect != 2'h3)
      && (captureModeSelect != `ATC_MODE_COUNTED || burstFrameCount != '0)
      && (framesPerTrigger != '0)
      && (transferMethodSelect == `ATC_XFER_BASIC);

   assign idle = r_reg.state == atc_pkg::ATC_IDLE;
   assign needArm = !r_reg.armed || r_reg.xferDirty;
   // an arm happens on request, or on a start that still needs one
   assign doArm = idle && (armCommand || (captureStartCommand && needArm));

   // ==============================
   // frame path: sensor stalls whenever the queue has no room
   assign captureEnable = (r_reg.state == atc_pkg::ATC_CAPT) && fifoInReady;
   assign pushValid = (r_reg.state == atc_pkg::ATC_CAPT) && frameDone && !captureAbortCommand;
   assign accepted = pushValid && fifoInReady;
   assign pop = txValid && txReady;

   // link drains on its own ready, no host pacing exists
   atc_fifo #(.W(`ATC_SIZE_W), .DEPTH(`ATC_FIFO_DEPTH)) queue (
      .clock(clock),
      .resetn(resetn),
      .inValid(pushValid),
      .inReady(fifoInReady),
      .inData(frameSize),
      .outValid(txValid),
      .outReady(txReady),
      .outData(txSize),
      .count(queuedBlockCount)
   );

   // ==============================
   // next-state logic for the whole block
   always_comb begin
      logic [16:0] remShift;
      logic [16:0] quoShift;
      logic load;
      logic burstEnd;
      logic lastFrame;
      remShift = '0;
      quoShift = '0;
      load = 1'b0;
      burstEnd = 1'b0;
      lastFrame = 1'b0;
      r_next = r_reg;
      r_next.autoArm = 1'b0;
      r_next.discard = 1'b0;

      // batch sessions hold off checks until their commit
      if (regBatchCommit && r_reg.regBatch) begin
         r_next.regBatch = 1'b0;
         r_next.regOk = setOk;
         load = setOk;
      end
      if (featureBatchCommit && r_reg.featBatch) begin
         r_next.featBatch = 1'b0;
         r_next.regOk = setOk;
         load = setOk;
      end
      // a begin in the commit cycle opens a new session, so the set wins
      if (regBatchBegin) begin
         r_next.regBatch = 1'b1;
      end
      if (featureBatchBegin) begin
         r_next.featBatch = 1'b1;
      end
      if (regSetValidate) begin
         r_next.regOk = setOk;
      end

      // arm: validate and latch the active settings
      if (doArm) begin
         r_next.regOk = setOk;
         r_next.armed = setOk;
         r_next.xferDirty = 1'b0;
         r_next.autoArm = !armCommand;
         load = load || setOk;
      end
      // a change in the same cycle as an arm still marks the arm stale
      if (transferSettingChanged) begin
         r_next.xferDirty = 1'b1;
      end
      if (load) begin
         r_next.actMode = captureModeSelect;
         r_next.actCount = burstFrameCount;
         r_next.actPerTrig = framesPerTrigger;
      end

      // capture sequencer
      case (r_reg.state)
         atc_pkg::ATC_IDLE: begin
            // abort and stop are ignored while idle
            if (captureStartCommand && (!needArm || setOk)) begin
               r_next.frameCnt = '0;
               r_next.burstCnt = '0;
               r_next.state = triggerModeOn ? atc_pkg::ATC_WAIT : atc_pkg::ATC_CAPT;
            end
         end
         atc_pkg::ATC_WAIT: begin
            if (captureAbortCommand) begin
               r_next.state = atc_pkg::ATC_IDLE;
               r_next.discard = 1'b1;
            end else if (captureStopCommand || r_reg.stopPend) begin
               r_next.state = atc_pkg::ATC_IDLE;
            end else if (triggerIn) begin
               r_next.burstCnt = '0;
               r_next.state = atc_pkg::ATC_CAPT;
            end
         end
         atc_pkg::ATC_CAPT: begin
            if (captureAbortCommand) begin
               r_next.state = atc_pkg::ATC_IDLE;
               r_next.discard = 1'b1;
            end else begin
               if (captureStopCommand) begin
                  r_next.stopPend = 1'b1;
               end
               if (accepted) begin
                  r_next.frameCnt = r_reg.frameCnt + 1'b1;
                  r_next.burstCnt = r_reg.burstCnt + 1'b1;
                  burstEnd = (r_reg.burstCnt + 1'b1) >= r_reg.actPerTrig;
                  lastFrame = (r_reg.actMode == `ATC_MODE_ONE_SHOT)
                     || (r_reg.actMode == `ATC_MODE_COUNTED
                         && (r_reg.frameCnt + 1'b1) >= r_reg.actCount);
                  if (lastFrame || ((r_reg.stopPend || captureStopCommand) && burstEnd)) begin
                     r_next.state = atc_pkg::ATC_IDLE;
                  end else if (burstEnd && triggerModeOn) begin
                     r_next.state = atc_pkg::ATC_WAIT;
                  end
               end
            end
         end
         default: begin
            r_next.state = atc_pkg::ATC_IDLE;
         end
      endcase

      // transmitted block statistics
      if (pop) begin
         if (!r_reg.seenAny || txSize > r_reg.largest) begin
            r_next.largest = txSize;
         end
         if (!r_reg.seenAny || txSize < r_reg.smallest) begin
            r_next.smallest = txSize;
         end
         r_next.seenAny = 1'b1;
         // leaky sum holds sixteen means, avoiding a sixteen-entry history
         r_next.meanSum = r_reg.meanSum - (r_reg.meanSum >> `ATC_MEAN_SHIFT)
            + {4'h0, txSize};
      end
      // end of capture clears largest and smallest, winning over a send
      if (!idle && r_next.state == atc_pkg::ATC_IDLE) begin
         r_next.largest = '0;
         r_next.smallest = '0;
         r_next.seenAny = 1'b0;
         r_next.stopPend = 1'b0;
      end

      // queue memory is what the resend reservation leaves over
      r_next.qMem = (resendBufferReservation >= `ATC_QUEUE_TOTAL_MB) ? 8'h00
         : `ATC_QUEUE_TOTAL_MB - resendBufferReservation;

      // serial divider: link rate over block size, one bit per cycle
      if (!r_reg.divBusy) begin
         r_next.divBusy = 1'b1;
         r_next.divStep = '0;
         r_next.divRem = '0;
         r_next.divQuo = `ATC_LINK_KB_PER_S;
         r_next.divDen = compressionOn ? meanSentBlock : configuredBlockSize;
      end else begin
         remShift = {r_reg.divRem[15:0], r_reg.divQuo[16]};
         quoShift = {r_reg.divQuo[15:0], 1'b0};
         if (remShift >= {1'b0, r_reg.divDen}) begin
            r_next.divRem = remShift - {1'b0, r_reg.divDen};
            r_next.divQuo = quoShift | 17'h00001;
         end else begin
            r_next.divRem = remShift;
            r_next.divQuo = quoShift;
         end
         r_next.divStep = r_reg.divStep + 1'b1;
         if (r_reg.divStep == `ATC_DIV_LAST) begin
            r_next.divBusy = 1'b0;
            // a zero size yields all ones, which the sensor limit then caps
            r_next.rate = (r_next.divQuo > {1'b0, sensorRateLimit}) ? sensorRateLimit
               : r_next.divQuo[15:0];
         end
      end
   end

   // state register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         r_reg <= '{state: atc_pkg::ATC_IDLE, default: '0};
      end else begin
         r_reg <= r_next;
      end
   end

   // ==============================
   // status and statistics outputs
   assign captureInProgress = !idle;
   assign awaitingTrigger = r_reg.state == atc_pkg::ATC_WAIT;
   assign acquisitionStatus = statusSelect ? awaitingTrigger : captureInProgress;
   assign queueMemoryMegabytes = r_reg.qMem;
   assign largestSentBlock = r_reg.largest;
   assign smallestSentBlock = r_reg.smallest;
   assign meanSentBlock = r_reg.meanSum[`ATC_SIZE_W+3:4];
   assign sustainableFrameRate = r_reg.rate;
   assign regSetOkFlag = r_reg.regOk;
   assign autoArmPulse = r_reg.autoArm;
   assign frameDiscard = r_reg.discard;

   // ==============================
   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence s_startUnarmed;
      idle && captureStartCommand && !armCommand && !r_reg.armed && setOk;
   endsequence
   sequence s_armedRun;
      autoArmPulse ##0 captureInProgress;
   endsequence

   AST_AUTO_ARM: assert property (s_startUnarmed |=> s_armedRun)
      else $error("start without arm did not arm and run");
   AST_NO_REARM: assert property (idle && captureStartCommand && r_reg.armed && !r_reg.xferDirty
      |=> !autoArmPulse && captureInProgress)
      else $error("arm repeated without a transfer setting change");
   AST_ABORT_NOW: assert property (!idle && captureAbortCommand
      |=> !captureInProgress && frameDiscard && queuedBlockCount <= $past(queuedBlockCount))
      else $error("abort did not end capture at once");
   AST_ABORT_IDLE: assert property (idle && captureAbortCommand && !captureStartCommand
      |=> idle && !frameDiscard)
      else $error("abort while idle changed state");
   AST_STOP_FRAME: assert property (r_reg.state == atc_pkg::ATC_CAPT && captureStopCommand
      && !captureAbortCommand && !accepted ##1 !captureAbortCommand && !accepted
      |=> captureInProgress)
      else $error("stop ended capture before the frame completed");
   AST_ONE_SHOT: assert property (r_reg.state == atc_pkg::ATC_CAPT && accepted
      && !captureAbortCommand && r_reg.actMode == `ATC_MODE_ONE_SHOT |=> idle)
      else $error("one-shot mode kept capturing");
   AST_STATS_CLEAR: assert property (!idle ##1 idle |-> largestSentBlock == '0
      && smallestSentBlock == '0)
      else $error("size statistics not cleared at stop");
   AST_MAX_TRACK: assert property (pop && r_reg.seenAny && txSize > largestSentBlock
      && !(captureInProgress && r_next.state == atc_pkg::ATC_IDLE)
      |=> largestSentBlock == $past(txSize))
      else $error("largest size missed a bigger block");
   AST_QUEUE_UP: assert property (accepted && !pop
      |=> queuedBlockCount == $past(queuedBlockCount) + 4'h1)
      else $error("queued count did not rise on a queued frame");
   AST_VALIDATE: assert property (regSetValidate && !doArm && !regBatchCommit && !featureBatchCommit
      |=> regSetOkFlag == $past(setOk))
      else $error("validate result not shown on the flag");
   AST_QMEM: assert property (resetn |=> queueMemoryMegabytes <= `ATC_QUEUE_TOTAL_MB
      && (($past(resendBufferReservation) < `ATC_QUEUE_TOTAL_MB) ->
      queueMemoryMegabytes + $past(resendBufferReservation) == `ATC_QUEUE_TOTAL_MB))
      else $error("queue memory not the complement of the reservation");
endmodule : atc_acq_ctrl

// file: tb/atc_link_sink.sv
`timescale 1ns/1ps
// ==============================
// host side of the link: takes queued blocks, sometimes at once, sometimes late
module atc_link_sink (
   input wire logic clock,
   input wire logic resetn,
   input wire logic hold,
   input wire logic txValid,
   output logic txReady
);
   // ready moves only just after an edge; random gaps stand for a busy host,
   // hold stalls the host completely so the queue can fill
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         txReady <= 1'h0;
      end else begin
         txReady <= !hold && ($urandom % 3 != 0);
      end
   end
endmodule : atc_link_sink

// file: tb/tb_top.sv
`timescale 1ns/1ps
`include "atc_defines.svh"
// ==============================
// signals
module tb_top;
   localparam logic [11:0] ARM = 12'h001, START = 12'h002, STOP = 12'h004, ABORT = 12'h008;
   localparam logic [11:0] XCHG = 12'h010, TRIG = 12'h020, RBB = 12'h040, RBC = 12'h080;
   localparam logic [11:0] FBB = 12'h100, FBC = 12'h200, VAL = 12'h400, FDONE = 12'h800;
   logic clock = 1'h0;
   logic resetn = 1'h0;
   logic hold = 1'h0;
   logic [11:0] cmd = 12'h000;
   logic [1:0] captureModeSelect = 2'h0;
   logic [15:0] burstFrameCount = 16'h0001, framesPerTrigger = 16'h0001, frameSize = 16'h0000;
   logic [15:0] configuredBlockSize = 16'h0400, sensorRateLimit = 16'hffff;
   logic transferMethodSelect = 1'h0, triggerModeOn = 1'h0, compressionOn = 1'h0, statusSelect = 1'h0;
   logic [7:0] resendBufferReservation = 8'h00;
   logic captureEnable, txValid, txReady, acquisitionStatus, captureInProgress, awaitingTrigger;
   logic regSetOkFlag, autoArmPulse, frameDiscard;
   logic [3:0] queuedBlockCount;
   logic [7:0] queueMemoryMegabytes;
   logic [15:0] txSize, largestSentBlock, smallestSentBlock, meanSentBlock, sustainableFrameRate;
   logic [19:0] mSum = 20'h00000;
   logic [15:0] mx, mn, s;
   logic seen = 1'h0;
   logic f;
   int error_cnt = 0, n_checks = 0, cyc = 0, badSel = 0;

   // ==============================
   // clock and hang guard
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         final_report();
      end
   end

   // device under test and the host model
   atc_acq_ctrl uut (.clock, .resetn, .armCommand(cmd[0]), .captureStartCommand(cmd[1]),
      .captureStopCommand(cmd[2]), .captureAbortCommand(cmd[3]), .captureModeSelect, .burstFrameCount,
      .framesPerTrigger, .transferMethodSelect, .transferSettingChanged(cmd[4]), .triggerModeOn,
      .triggerIn(cmd[5]), .regBatchBegin(cmd[6]), .regBatchCommit(cmd[7]), .featureBatchBegin(cmd[8]),
      .featureBatchCommit(cmd[9]), .regSetValidate(cmd[10]), .captureEnable, .frameDone(cmd[11]),
      .frameSize, .txValid, .txSize, .txReady, .resendBufferReservation, .compressionOn,
      .configuredBlockSize, .sensorRateLimit, .statusSelect, .acquisitionStatus, .captureInProgress,
      .awaitingTrigger, .queuedBlockCount, .queueMemoryMegabytes, .largestSentBlock, .smallestSentBlock,
      .meanSentBlock, .sustainableFrameRate, .regSetOkFlag, .autoArmPulse, .frameDiscard);
   atc_link_sink sink (.clock, .resetn, .hold, .txValid, .txReady);

   // ==============================
   // reporting and comparison
   task final_report;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report

   // case equality, so an unknown never matches a known expected value
   task chk1(input logic g, input logic e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: flag %h expected %h", $time, g, e);
      end
   endtask : chk1

   task chkV(input logic [19:0] g, input logic [19:0] e);
      n_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error at %0t: value %h expected %h", $time, g, e);
      end
   endtask : chkV

   function automatic logic [19:0] expMem(input logic [7:0] r);
      return (r > `ATC_QUEUE_TOTAL_MB) ? 20'h0 : 20'(`ATC_QUEUE_TOTAL_MB - r);
   endfunction : expMem

   function automatic logic [19:0] expRate(input logic [15:0] sz, input logic [15:0] lim);
      logic [19:0] r;
      r = 20'(`ATC_LINK_KB_PER_S) / 20'(sz);
      return (r > 20'(lim)) ? 20'(lim) : r;
   endfunction : expRate

   // ==============================
   // drivers; each returns just after the edge that took its request
   task pulse(input logic [11:0] m, input logic [15:0] sz = 16'h0000);
      @(posedge clock);
      cmd <= m;
      frameSize <= sz;
      @(posedge clock);
      cmd <= 12'h000;
      #1;
   endtask : pulse

   // the sensor may finish a frame only while capture is enabled
   task frame;
      int n;
      n = 0;
      while (captureEnable !== 1'h1 && n < 200) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk1(captureEnable, 1'h1);
      s = 16'h0040 + 16'($urandom % 4096);
      pulse(FDONE, s);
      mSum = mSum - (mSum >> `ATC_MEAN_SHIFT) + 20'(s);
      mx = (seen && mx > s) ? mx : s;
      mn = (seen && mn < s) ? mn : s;
      seen = 1'h1;
   endtask : frame

   task drain;
      int n;
      n = 0;
      while (queuedBlockCount !== 4'h0 && n < 500) begin
         @(posedge clock);
         #1;
         n++;
      end
      chkV(20'(queuedBlockCount), 20'h0);
   endtask : drain

   task setup(input logic [1:0] m, input logic [15:0] c, input logic [15:0] p);
      @(posedge clock);
      captureModeSelect <= m;
      burstFrameCount <= c;
      framesPerTrigger <= p;
      pulse(ARM);
      chk1(regSetOkFlag, 1'h1);
   endtask : setup

   // each bad call breaks a different setting in turn
   task setBad(input logic b);
      if (b) badSel++;
      @(posedge clock);
      captureModeSelect <= (b && badSel % 4 == 0) ? 2'h3 : (b && badSel % 4 == 2) ? `ATC_MODE_COUNTED
         : `ATC_MODE_ONE_SHOT;
      transferMethodSelect <= b && badSel % 4 == 1;
      burstFrameCount <= (b && badSel % 4 == 2) ? 16'h0000 : 16'h0001;
      framesPerTrigger <= (b && badSel % 4 == 3) ? 16'h0000 : 16'h0001;
   endtask : setBad

   // ==============================
   // main sequence
   initial begin
      logic [7:0] tbl [5];
      void'($urandom(32'h92f8));
      repeat (6) @(posedge clock);
      resetn <= 1'h1;
      #1;
      chk1(captureInProgress, 1'h0);
      pulse(ABORT);
      chk1(frameDiscard, 1'h0);
      chk1(captureInProgress, 1'h0);
      // first start arms itself; later ones only after a transfer change
      @(posedge clock) hold <= 1'h1;
      for (int i = 0; i < 3; i++) begin
         if (i == 2) pulse(XCHG);
         pulse(START);
         chk1(autoArmPulse, i != 1);
         chk1(captureInProgress, 1'h1);
         frame();
         chk1(captureInProgress, 1'h0);
         chkV(20'(queuedBlockCount), 20'(i + 1));
      end
      chk1(txValid, 1'h1);
      @(posedge clock) hold <= 1'h0;
      drain();
      // counted burst of random length
      setup(`ATC_MODE_COUNTED, 16'(2 + $urandom % 4), 16'h0001);
      pulse(START);
      chk1(autoArmPulse, 1'h0);
      repeat (burstFrameCount) begin
         chk1(captureInProgress, 1'h1);
         frame();
      end
      chk1(captureInProgress, 1'h0);
      drain();
      // streaming statistics, then a stop with the host stalled
      setup(`ATC_MODE_CONTINUOUS, 16'h0001, 16'h0001);
      seen = 1'h0;
      // an abort with the queue empty clears leftover size statistics
      pulse(START);
      pulse(ABORT);
      pulse(START);
      repeat (5) frame();
      drain();
      chkV(20'(largestSentBlock), 20'(mx));
      chkV(20'(smallestSentBlock), 20'(mn));
      chkV(20'(meanSentBlock), mSum >> `ATC_MEAN_SHIFT);
      @(posedge clock) hold <= 1'h1;
      pulse(STOP);
      if (captureInProgress === 1'h1) frame();
      chk1(captureInProgress, 1'h0);
      chkV(20'(largestSentBlock), 20'h0);
      chkV(20'(smallestSentBlock), 20'h0);
      // fill the queue until it refuses, then abort
      pulse(START);
      for (int i = 0; i < 9 && captureEnable === 1'h1; i++) frame();
      chkV(20'(queuedBlockCount), 20'(`ATC_FIFO_DEPTH));
      chk1(captureEnable, 1'h0);
      pulse(ABORT);
      chk1(frameDiscard, 1'h1);
      chk1(captureInProgress, 1'h0);
      @(posedge clock) hold <= 1'h0;
      drain();
      chkV(20'(meanSentBlock), mSum >> `ATC_MEAN_SHIFT);
      // stop inside a two-frame burst finishes the burst
      setup(`ATC_MODE_CONTINUOUS, 16'h0001, 16'h0002);
      pulse(START);
      frame();
      pulse(STOP);
      chk1(captureInProgress, 1'h1);
      frame();
      chk1(captureInProgress, 1'h0);
      // trigger wait: status selection, abort of the wait, then a trigger
      @(posedge clock) triggerModeOn <= 1'h1;
      setup(`ATC_MODE_ONE_SHOT, 16'h0001, 16'h0001);
      for (int i = 0; i < 2; i++) begin
         pulse(START);
         chk1(awaitingTrigger, 1'h1);
         @(posedge clock) statusSelect <= i[0];
         #1;
         chk1(acquisitionStatus, 1'h1);
         pulse(i == 0 ? ABORT : TRIG);
         chk1(frameDiscard, i == 0);
         chk1(captureInProgress, i != 0);
      end
      frame();
      @(posedge clock) triggerModeOn <= 1'h0;
      drain();
      // checks deferred during batches, done at commit or on demand
      f = 1'h1;
      for (int k = 0; k < 3; k++) begin
         for (int b = 1; b >= 0; b--) begin
            if (k > 0) pulse(k == 1 ? RBB : FBB);
            setBad(b[0]);
            repeat (3) @(posedge clock);
            #1;
            chk1(regSetOkFlag, f);
            pulse(k == 0 ? VAL : k == 1 ? RBC : FBC);
            f = !b[0];
            chk1(regSetOkFlag, f);
         end
      end
      setBad(1'h1);
      pulse(RBC);
      chk1(regSetOkFlag, 1'h1);
      pulse(ARM);
      chk1(regSetOkFlag, 1'h0);
      pulse(XCHG);
      pulse(START);
      chk1(captureInProgress, 1'h0);
      setBad(1'h0);
      // queue memory against the resend reservation
      tbl = '{8'h00, 8'h60, 8'h61, 8'hff, 8'h00};
      tbl[4] = 8'($urandom);
      foreach (tbl[i]) begin
         @(posedge clock) resendBufferReservation <= tbl[i];
         repeat (2) @(posedge clock);
         #1;
         chkV(20'(queueMemoryMegabytes), expMem(tbl[i]));
      end
      // sustainable rate, with and without compression, capped and not
      for (int i = 0; i < 4; i++) begin
         @(posedge clock);
         compressionOn <= i[1];
         sensorRateLimit <= i[0] ? 16'h0005 : 16'hffff;
         configuredBlockSize <= 16'h0100 + 16'($urandom % 4096);
         repeat (50) @(posedge clock);
         #1;
         s = i[1] ? 16'(mSum >> `ATC_MEAN_SHIFT) : configuredBlockSize;
         chkV(20'(sustainableFrameRate), expRate(s, sensorRateLimit));
      end
      final_report();
   end
endmodule : tb_top
